// ---- hw/ldc_pkg.sv ----
// package: register map, field layout, states and carrier types for delay calibration registers
package ldc_pkg;
  localparam logic [7:0] LDC_OFS_OVR_CTRL = 8'h70;
  localparam logic [7:0] LDC_OFS_MEAS_STAT = 8'h74;
  localparam logic [7:0] LDC_OFS_RTD_CTRL = 8'h80;
  localparam logic [7:0] LDC_OFS_IRQ_STAT = 8'h90;
  localparam logic [7:0] LDC_OFS_IRQ_MASK = 8'h94;
  localparam int LDC_OVR_EN_BIT = 16;
  localparam int LDC_TXD_W = 12;
  localparam int LDC_MEAS_W = 16;
  localparam int LDC_RTD_ST_LSB = 28;
  localparam int LDC_RTD_RST_BIT = 26;
  localparam int LDC_RTD_BYP_BIT = 25;
  localparam int LDC_RTD_EN_BIT = 24;
  localparam int LDC_RTD_TGT_W = 20;
  localparam int LDC_IRQ_W = 3;
  localparam logic [LDC_TXD_W-1:0] LDC_TXD_RST = 12'h000;
  localparam logic [LDC_MEAS_W-1:0] LDC_MEAS_RST = 16'h0000;
  localparam logic [LDC_RTD_TGT_W-1:0] LDC_TGT_RST = 20'h00000;
  localparam logic [2:0] LDC_CTRL_RST = 3'h0;
  localparam logic [LDC_IRQ_W-1:0] LDC_IRQ_RST = 3'h0;
  localparam logic [1:0] LDC_ST_OFF = 2'h0;
  localparam logic [1:0] LDC_ST_RUN = 2'h1;
  localparam logic [1:0] LDC_ST_DONE = 2'h2;
  localparam logic [1:0] LDC_ST_ERR = 2'h3;
  localparam logic [23:0] LDC_CAL_TIMEOUT = 24'h100000;
  localparam logic [LDC_RTD_TGT_W-1:0] LDC_CAL_TOL = 20'h00002;
  localparam int LDC_IRQ_DONE = 0;
  localparam int LDC_IRQ_ERR = 1;
  localparam int LDC_IRQ_MEAS = 2;

  typedef enum logic [3:0] {
    LDC_S_OFF = 4'h1,
    LDC_S_RUN = 4'h2,
    LDC_S_DONE = 4'h4,
    LDC_S_ERR = 4'h8
  } ldc_cal_state_t;

  typedef struct packed {
    logic rst;
    logic byp;
    logic en;
    logic [LDC_RTD_TGT_W-1:0] target;
  } ldc_rtd_cfg_t;

  typedef struct packed {
    logic valid;
    logic [LDC_MEAS_W-1:0] delay;
  } ldc_meas_t;
endpackage : ldc_pkg

// ---- hw/ldc_sync.sv ----
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module ldc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : ldc_sync
`default_nettype wire

// ---- hw/ldc_rtd_cal.sv ----
// round-trip delay calibration engine: state machine on measured round trip vs target
`timescale 1ns/1ps
`default_nettype none
module ldc_rtd_cal (
  input wire logic pclk,
  input wire logic presetn,
  input wire ldc_pkg::ldc_rtd_cfg_t cfg,
  input wire logic rtd_valid,
  input wire logic [ldc_pkg::LDC_RTD_TGT_W-1:0] rtd_meas,
  output logic [1:0] status,
  output logic bypass,
  output logic adjust_up,
  output logic adjust_dn
);
  ldc_pkg::ldc_cal_state_t state_r, state_nxt;
  logic [23:0] tmo_r;
  logic [ldc_pkg::LDC_RTD_TGT_W-1:0] diff;
  logic meas_hi, meas_lo, in_tol, timed_out;

  // compare measured round trip against target with tolerance
  assign meas_hi = rtd_meas > cfg.target;
  assign diff = meas_hi ? (rtd_meas - cfg.target) : (cfg.target - rtd_meas);
  assign in_tol = diff <= ldc_pkg::LDC_CAL_TOL;
  assign meas_lo = !meas_hi && !in_tol;
  assign timed_out = tmo_r == ldc_pkg::LDC_CAL_TIMEOUT;

  // state transitions; reset bit beats bypass and enable
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ldc_pkg::LDC_S_OFF: if (cfg.en && !cfg.byp && !cfg.rst) state_nxt = ldc_pkg::LDC_S_RUN;
      ldc_pkg::LDC_S_RUN: begin
        if (cfg.rst || !cfg.en || cfg.byp) state_nxt = ldc_pkg::LDC_S_OFF;
        else if (rtd_valid && in_tol) state_nxt = ldc_pkg::LDC_S_DONE;
        else if (timed_out) state_nxt = ldc_pkg::LDC_S_ERR;
      end
      ldc_pkg::LDC_S_DONE: begin
        if (cfg.rst || !cfg.en || cfg.byp) state_nxt = ldc_pkg::LDC_S_OFF;
        else if (rtd_valid && !in_tol) state_nxt = ldc_pkg::LDC_S_RUN;
      end
      ldc_pkg::LDC_S_ERR: if (cfg.rst) state_nxt = ldc_pkg::LDC_S_OFF; // error held until reset bit
      default: state_nxt = ldc_pkg::LDC_S_OFF;
    endcase
  end

  // state register, timeout counter and registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ldc_pkg::LDC_S_OFF;
      tmo_r <= '0;
      status <= ldc_pkg::LDC_ST_OFF;
      bypass <= 1'b0;
      adjust_up <= 1'b0;
      adjust_dn <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmo_r <= (state_nxt == ldc_pkg::LDC_S_RUN && state_r == ldc_pkg::LDC_S_RUN) ? tmo_r + 24'h000001 : 24'h000000;
      bypass <= cfg.byp && !cfg.rst;
      adjust_up <= (state_nxt == ldc_pkg::LDC_S_RUN) && rtd_valid && meas_lo;
      adjust_dn <= (state_nxt == ldc_pkg::LDC_S_RUN) && rtd_valid && meas_hi && !in_tol;
      case (state_nxt)
        ldc_pkg::LDC_S_RUN: status <= ldc_pkg::LDC_ST_RUN;
        ldc_pkg::LDC_S_DONE: status <= ldc_pkg::LDC_ST_DONE;
        ldc_pkg::LDC_S_ERR: status <= ldc_pkg::LDC_ST_ERR;
        default: status <= ldc_pkg::LDC_ST_OFF;
      endcase
    end
  end
endmodule : ldc_rtd_cal
`default_nettype wire

// ---- hw/ldc_regs.sv ----
// APB register bank for link delay calibration: slave override, measured delay, round-trip calibration
`timescale 1ns/1ps
`default_nettype none
module ldc_regs #(
  parameter bit IS_SLAVE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_rcv_en,
  input wire logic link_txd_valid,
  input wire logic [ldc_pkg::LDC_TXD_W-1:0] link_txd,
  input wire logic meas_valid,
  input wire logic [ldc_pkg::LDC_MEAS_W-1:0] meas_delay,
  input wire logic rtd_valid,
  input wire logic [ldc_pkg::LDC_RTD_TGT_W-1:0] rtd_meas,
  output logic [ldc_pkg::LDC_TXD_W-1:0] tx_delay_out,
  output logic tx_delay_valid,
  output logic cal_bypass,
  output logic cal_adjust_up,
  output logic cal_adjust_dn,
  output logic irq
);
  logic ovr_en_r;
  logic [ldc_pkg::LDC_TXD_W-1:0] ovr_txd_r;
  ldc_pkg::ldc_meas_t meas_r;
  ldc_pkg::ldc_rtd_cfg_t rtd_cfg_r;
  logic [ldc_pkg::LDC_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
  logic [1:0] rtd_status, rtd_status_d_r;
  logic [ldc_pkg::LDC_MEAS_W:0] meas_sync;
  logic rtd_bypass;

  // bus decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_ovr = IS_SLAVE && (paddr == ldc_pkg::LDC_OFS_OVR_CTRL);
  wire hit_meas = IS_SLAVE && (paddr == ldc_pkg::LDC_OFS_MEAS_STAT);
  wire hit_rtd = !IS_SLAVE && (paddr == ldc_pkg::LDC_OFS_RTD_CTRL);
  wire hit_ist = paddr == ldc_pkg::LDC_OFS_IRQ_STAT;
  wire hit_imk = paddr == ldc_pkg::LDC_OFS_IRQ_MASK;
  wire hit_any = hit_ovr || hit_meas || hit_rtd || hit_ist || hit_imk;
  wire [ldc_pkg::LDC_IRQ_W-1:0] ist_clr = (wr_en && hit_ist) ? pwdata[ldc_pkg::LDC_IRQ_W-1:0] : '0;

  // measured delay arrives from the delay-measurement clock domain; sync level-held value
  ldc_sync #(.W(ldc_pkg::LDC_MEAS_W + 1)) u_meas_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({meas_valid, meas_delay}),
    .q(meas_sync)
  );

  // round-trip calibration engine
  ldc_rtd_cal u_rtd (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(rtd_cfg_r),
    .rtd_valid(rtd_valid),
    .rtd_meas(rtd_meas),
    .status(rtd_status),
    .bypass(rtd_bypass),
    .adjust_up(cal_adjust_up),
    .adjust_dn(cal_adjust_dn)
  );
  // read mux; reserved bits zero
  wire [31:0] rd_ovr = {15'h0000, ovr_en_r, 4'h0, ovr_txd_r};
  wire [31:0] rd_meas = {16'h0000, meas_r.delay};
  wire [31:0] rd_rtd = {2'h0, rtd_status, 1'b0, rtd_cfg_r.rst, rtd_cfg_r.byp, rtd_cfg_r.en, 4'h0,
                        rtd_cfg_r.target};
  wire [31:0] rd_ist = {29'h00000000, irq_stat_r};
  wire [31:0] rd_imk = {29'h00000000, irq_mask_r};
  wire [31:0] rd_val = hit_ovr ? rd_ovr : hit_meas ? rd_meas : hit_rtd ? rd_rtd :
                       hit_ist ? rd_ist : hit_imk ? rd_imk : 32'h00000000;

  // events: calibration done, calibration error, new measured delay
  assign irq_evt[ldc_pkg::LDC_IRQ_DONE] = !IS_SLAVE && (rtd_status == ldc_pkg::LDC_ST_DONE)
                                          && (rtd_status_d_r != ldc_pkg::LDC_ST_DONE);
  assign irq_evt[ldc_pkg::LDC_IRQ_ERR] = !IS_SLAVE && (rtd_status == ldc_pkg::LDC_ST_ERR)
                                         && (rtd_status_d_r != ldc_pkg::LDC_ST_ERR);
  assign irq_evt[ldc_pkg::LDC_IRQ_MEAS] = IS_SLAVE && meas_sync[ldc_pkg::LDC_MEAS_W]
                                          && (meas_sync[ldc_pkg::LDC_MEAS_W-1:0] != meas_r.delay);

  // transmit delay selection: override wins over link-carried value
  wire use_ovr = IS_SLAVE && ovr_en_r;
  wire link_ok = IS_SLAVE && !ovr_en_r && link_rcv_en && link_txd_valid;

  // software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_en_r <= 1'b0;
      ovr_txd_r <= ldc_pkg::LDC_TXD_RST;
      rtd_cfg_r <= '{rst: 1'b0, byp: 1'b0, en: 1'b0, target: ldc_pkg::LDC_TGT_RST};
      irq_mask_r <= ldc_pkg::LDC_IRQ_RST;
    end else if (wr_en) begin
      if (hit_ovr) begin
        ovr_en_r <= pwdata[ldc_pkg::LDC_OVR_EN_BIT];
        ovr_txd_r <= pwdata[ldc_pkg::LDC_TXD_W-1:0];
      end
      if (hit_rtd) begin
        rtd_cfg_r.rst <= pwdata[ldc_pkg::LDC_RTD_RST_BIT];
        rtd_cfg_r.byp <= pwdata[ldc_pkg::LDC_RTD_BYP_BIT];
        rtd_cfg_r.en <= pwdata[ldc_pkg::LDC_RTD_EN_BIT];
        rtd_cfg_r.target <= pwdata[ldc_pkg::LDC_RTD_TGT_W-1:0];
      end
      if (hit_imk) irq_mask_r <= pwdata[ldc_pkg::LDC_IRQ_W-1:0];
    end
  end

  // status, measured delay and sticky interrupt bits; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_r <= '{valid: 1'b0, delay: ldc_pkg::LDC_MEAS_RST};
      rtd_status_d_r <= ldc_pkg::LDC_ST_OFF;
      irq_stat_r <= ldc_pkg::LDC_IRQ_RST;
      irq <= 1'b0;
    end else begin
      if (IS_SLAVE && meas_sync[ldc_pkg::LDC_MEAS_W]) meas_r <= '{valid: 1'b1, delay: meas_sync[15:0]};
      rtd_status_d_r <= rtd_status;
      irq_stat_r <= (irq_stat_r & ~ist_clr) | irq_evt;
      irq <= |(((irq_stat_r & ~ist_clr) | irq_evt) & irq_mask_r);
    end
  end

  // transmit delay output and bypass flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_delay_out <= ldc_pkg::LDC_TXD_RST;
      tx_delay_valid <= 1'b0;
      cal_bypass <= 1'b0;
    end else begin
      if (use_ovr) tx_delay_out <= ovr_txd_r;
      else if (link_ok) tx_delay_out <= link_txd;
      tx_delay_valid <= use_ovr || link_ok || (tx_delay_valid && IS_SLAVE && !ovr_en_r && link_rcv_en);
      cal_bypass <= rtd_bypass;
    end
  end

  // apb answer: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h00000000;
    end
  end
  wire unused_ok = rd_en;
endmodule : ldc_regs
`default_nettype wire

// ---- verif/ldc_regs_checker.sv ----
// checker: bus timing and field relations at the register bank ports
`timescale 1ns/1ps
`default_nettype none
module ldc_regs_checker #(
  parameter bit IS_SLAVE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ldc_pkg::LDC_TXD_W-1:0] tx_delay_out,
  input wire logic tx_delay_valid,
  input wire logic cal_bypass
);
  logic [31:0] ovr_r;
  logic [31:0] rtd_r;
  // decode of completed accesses and per-address reserved masks
  wire wr_acc = psel && penable && pready && pwrite;
  wire rd_acc = psel && penable && pready && !pwrite;
  wire absent = IS_SLAVE ? paddr == 8'h80 : (paddr == 8'h70 || paddr == 8'h74);
  wire [31:0] rsv = paddr == 8'h70 ? 32'hFFFEF000 : paddr == 8'h74 ? 32'hFFFF0000 : paddr == 8'h80 ? 32'hC8F00000 : 32'h0;
  // shadow of the control words as written over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r <= 32'h0;
      rtd_r <= 32'h0;
    end else if (wr_acc && paddr == 8'h70) begin
      ovr_r <= pwdata;
    end else if (wr_acc && paddr == 8'h80) begin
      rtd_r <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable && pready;
  endsequence
  AST_PREADY_NEXT: assert property (s_setup |=> s_acc)
    else $error("no answer in the cycle after setup");
  AST_PREADY_CAUSE: assert property (pready |-> $past(psel && !penable))
    else $error("answer without a setup cycle");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  AST_RSV_ZERO: assert property (rd_acc |-> (prdata & rsv) == 32'h0)
    else $error("reserved bits read nonzero");
  AST_ROLE_ABSENT: assert property (s_acc and absent |-> pslverr && prdata == 32'h0)
    else $error("absent register answered");
  AST_OVR_SEL: assert property (IS_SLAVE && ovr_r[16] && $stable(ovr_r) |-> tx_delay_out == ovr_r[11:0] && tx_delay_valid)
    else $error("override delay not selected");
  AST_BYP_FOLLOW: assert property (!IS_SLAVE && $rose(rtd_r[25]) && !rtd_r[26] |-> ##[1:4] cal_bypass)
    else $error("bypass not entered");
  AST_RST_OFF: assert property (!IS_SLAVE && rd_acc && paddr == 8'h80 && rtd_r[26] && $past(rtd_r[26], 2) |-> prdata[29:28] == 2'h0)
    else $error("status not off under reset");
endmodule : ldc_regs_checker
`default_nettype wire

// ---- verif/ldc_peer_model.sv ----
// peer link core model: link-carried delay, measured delay level, round-trip pulses
`timescale 1ns/1ps
`default_nettype none
module ldc_peer_model (
  input wire logic presetn,
  input wire logic meas_go,
  input wire logic send_rtd,
  input wire logic [19:0] rtd_val,
  output logic link_txd_valid,
  output logic [11:0] link_txd,
  output logic meas_valid,
  output logic [15:0] meas_delay,
  output logic rtd_valid,
  output logic [19:0] rtd_meas
);
  // measured delay and round-trip lines not qualified by their valid show the inverse pattern, not stale data; link_txd is always 12'hABC
  assign link_txd_valid = presetn;
  assign link_txd = 12'hABC;
  assign meas_valid = meas_go;
  assign meas_delay = meas_go ? 16'h1234 : 16'hEDCB;
  assign rtd_valid = send_rtd;
  assign rtd_meas = send_rtd ? rtd_val : ~rtd_val;
endmodule : ldc_peer_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// top testbench: bus traffic to slave and master variants with a peer model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel_s = 1'b0, psel_m = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rdata, prdata_s, prdata_m;
  logic pready_s, pready_m, perr_s, perr_m, err, irq_s, adj_up_m, adj_dn_m, byp_m, txv_s;
  logic meas_go = 1'b0, send_rtd = 1'b0, link_rcv_en = 1'b1, link_txd_valid, meas_valid, rtd_valid;
  logic [11:0] link_txd, txd_s;
  logic [15:0] meas_delay;
  logic [19:0] rtd_val = 20'h0, rtd_meas;
  int bad_count = 0, checks = 0;
  always #2.5 pclk = ~pclk;
  // slave and master variants share the bus and the peer
  ldc_regs #(.IS_SLAVE(1'b1)) u_ldc_regs (.pclk, .presetn, .psel(psel_s), .penable, .pwrite, .paddr, .pwdata,
    .prdata(prdata_s), .pready(pready_s), .pslverr(perr_s), .link_rcv_en, .link_txd_valid, .link_txd, .meas_valid,
    .meas_delay, .rtd_valid, .rtd_meas, .tx_delay_out(txd_s), .tx_delay_valid(txv_s), .cal_bypass(),
    .cal_adjust_up(), .cal_adjust_dn(), .irq(irq_s));
  ldc_regs #(.IS_SLAVE(1'b0)) u_ldc_regs_m (.pclk, .presetn, .psel(psel_m), .penable, .pwrite, .paddr, .pwdata,
    .prdata(prdata_m), .pready(pready_m), .pslverr(perr_m), .link_rcv_en, .link_txd_valid, .link_txd, .meas_valid,
    .meas_delay, .rtd_valid, .rtd_meas, .tx_delay_out(), .tx_delay_valid(), .cal_bypass(byp_m),
    .cal_adjust_up(adj_up_m), .cal_adjust_dn(adj_dn_m), .irq());
  ldc_peer_model u_ldc_peer_model (.presetn, .meas_go, .send_rtd, .rtd_val, .link_txd_valid, .link_txd,
    .meas_valid, .meas_delay, .rtd_valid, .rtd_meas);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one bus transfer: setup, then access held until ready is sampled
  task automatic xfer(input logic m, input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel_s <= !m;
    psel_m <= m;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while ((m ? pready_m : pready_s) !== 1'b1 && n < 16);
    rdata = m ? prdata_m : prdata_s;
    err = m ? perr_m : perr_s;
    psel_s <= 1'b0;
    psel_m <= 1'b0;
    penable <= 1'b0;
    if (n == 16 && (m ? pready_m : pready_s) !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
  endtask : xfer
  task automatic rd(input logic m, input logic [7:0] a, input logic [31:0] exp);
    xfer(m, 1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(1'b0, 8'h70, 32'h0);
    rd(1'b0, 8'h74, 32'h0);
    rd(1'b1, 8'h80, 32'h0);
    chk(32'({txv_s, txd_s}), 32'h1ABC);
    xfer(1'b0, 1'b1, 8'h70, 32'hFFFFFFFF);
    rd(1'b0, 8'h70, 32'h00010FFF);
    chk(32'(txd_s), 32'hFFF);
    xfer(1'b0, 1'b1, 8'h70, 32'h00000123);
    rd(1'b0, 8'h70, 32'h00000123);
    chk(32'(txd_s), 32'hABC);
    xfer(1'b0, 1'b1, 8'h70, 32'h00010456);
    rd(1'b0, 8'h70, 32'h00010456);
    chk(32'(txd_s), 32'h456);
    // receive enable low with override off: no link-carried delay is taken
    xfer(1'b0, 1'b1, 8'h70, 32'h00000000);
    link_rcv_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(txv_s), 32'h0);
    link_rcv_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'({txv_s, txd_s}), 32'h1ABC);
    rd(1'b0, 8'h80, 32'h0);
    chk(32'(err), 32'h1);
    xfer(1'b1, 1'b1, 8'h70, 32'hFFFFFFFF);
    rd(1'b1, 8'h70, 32'h0);
    chk(32'(err), 32'h1);
    meas_go <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(1'b0, 8'h74, 32'h1234);
    xfer(1'b0, 1'b1, 8'h74, 32'hFFFFFFFF);
    rd(1'b0, 8'h74, 32'h1234);
    rd(1'b0, 8'h90, 32'h4);
    // interrupt level follows the mask, then falls on write-one-to-clear
    xfer(1'b0, 1'b1, 8'h94, 32'h4);
    repeat (2) @(posedge pclk);
    chk(32'(irq_s), 32'h1);
    xfer(1'b0, 1'b1, 8'h94, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq_s), 32'h0);
    xfer(1'b0, 1'b1, 8'h94, 32'h4);
    repeat (2) @(posedge pclk);
    chk(32'(irq_s), 32'h1);
    xfer(1'b0, 1'b1, 8'h90, 32'h4);
    rd(1'b0, 8'h90, 32'h0);
    chk(32'(irq_s), 32'h0);
    xfer(1'b1, 1'b1, 8'h80, 32'hC1F00100);
    repeat (4) @(posedge pclk);
    rd(1'b1, 8'h80, 32'h11000100);
    rtd_val <= 20'h00101;
    send_rtd <= 1'b1;
    @(posedge pclk);
    send_rtd <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(1'b1, 8'h80, 32'h21000100);
    rd(1'b1, 8'h90, 32'h1);
    xfer(1'b1, 1'b1, 8'h80, 32'h04000100);
    rd(1'b1, 8'h80, 32'h04000100);
    xfer(1'b1, 1'b1, 8'h80, 32'h02000100);
    repeat (4) @(posedge pclk);
    chk(32'(byp_m), 32'h1);
    xfer(1'b1, 1'b1, 8'h80, 32'h04000100);
    repeat (4) @(posedge pclk);
    chk(32'(byp_m), 32'h0);
    // running calibration steers down on a long round trip, up on a short one
    xfer(1'b1, 1'b1, 8'h80, 32'h01000100);
    repeat (2) @(posedge pclk);
    rtd_val <= 20'h00200;
    send_rtd <= 1'b1;
    @(posedge pclk);
    send_rtd <= 1'b0;
    @(posedge pclk);
    chk(32'({adj_up_m, adj_dn_m}), 32'h1);
    rtd_val <= 20'h00010;
    send_rtd <= 1'b1;
    @(posedge pclk);
    send_rtd <= 1'b0;
    @(posedge pclk);
    chk(32'({adj_up_m, adj_dn_m}), 32'h2);
    rd(1'b1, 8'h80, 32'h11000100);
    end_of_test();
  end
endmodule : tb_top
bind ldc_regs ldc_regs_checker #(.IS_SLAVE(IS_SLAVE)) u_ldc_regs_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_delay_out, .tx_delay_valid, .cal_bypass);
`default_nettype wire
